// ==== bench/rdf_host_model.sv ====
// host model: serial master that fills and drains the buffers
`timescale 1ns/1ns
`default_nettype none
module rdf_host_model (
  // clock
  input wire logic core_clk,
  // serial pins
  output logic cs_n_pin,
  output logic sclk_pin,
  input wire logic so_out,
  input wire logic so_oe_n,
  output logic si_pin
);
  // a released output floats; its inverse exposes a stale sample
  wire logic so_line = so_oe_n ? ~so_out : so_out;
  // ======================================================
  // framing: buffer data moves only inside frames
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    si_pin = 1'b0;
  end

  // select, then let the slave sync before the first clock rise
  task automatic sel();
    @(posedge core_clk);
    cs_n_pin <= 1'b0;
    repeat (6) @(posedge core_clk);
  endtask

  // release; idle data line flips so no stale bit looks valid
  task automatic desel();
    @(posedge core_clk);
    cs_n_pin <= 1'b1;
    si_pin <= ~si_pin;
    repeat (6) @(posedge core_clk);
  endtask

  // one byte each way, msb first, mode 0, four low and four high cycles
  task automatic shift(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) begin
      si_pin <= o[k];
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      i[k] = so_line;
      @(posedge core_clk);
      sclk_pin <= 1'b1;
      repeat (4) @(posedge core_clk);
      sclk_pin <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/rdf_radio_fifo_tb.sv ====
// self-checking bench for the radio data buffer pair
`timescale 1ns/1ns
`default_nettype none
module rdf_radio_fifo_tb;
  logic core_clk, reset, reg_wr, reg_rd;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rx_byte_data, tx_byte_data;
  logic cs_n_pin, sclk_pin, si_pin, so_out, so_oe_n;
  logic rx_byte_valid, tx_byte_req, tx_byte_valid;
  logic general_output_pin, irq;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;

  // ======================================================
  // design and host
  rdf_radio_fifo dut_u (.core_clk, .reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .cs_n_pin, .sclk_pin, .si_pin,
    .so_out, .so_oe_n, .rx_byte_valid, .rx_byte_data, .tx_byte_req,
    .tx_byte_valid, .tx_byte_data, .general_output_pin, .irq);
  rdf_host_model host_u (.core_clk, .cs_n_pin, .sclk_pin, .so_out,
    .so_oe_n, .si_pin);

  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ======================================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // registered outputs need a few edges to follow their cause
  task automatic settle();
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wr_reg(logic [3:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk_reg(string n, logic [3:0] a, logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic push_rx(logic [7:0] d);
    @(posedge core_clk);
    rx_byte_valid <= 1'b1;
    rx_byte_data <= d;
    @(posedge core_clk);
    rx_byte_valid <= 1'b0;
  endtask
  // one frame: header, then one buffer byte
  task automatic frame(logic [7:0] h, o, es, ed);
    logic [7:0] s, d;
    host_u.sel();
    host_u.shift(h, s);
    chk("status byte", es, s); // fill level by direction
    host_u.shift(o, d);
    if (h[7]) chk("read byte", ed, d); // oldest byte first
    host_u.desel();
  endtask

  // ======================================================
  // scenarios
  task automatic t_reset();
    settle();
    chk("irq", 1'b0, irq);
    chk("pin", 1'b0, general_output_pin);
    chk("so enable", 1'b1, so_oe_n);
    chk_reg("cfg", rdf_pkg::REG_CFG, 8'h07);
    chk_reg("pin sel", rdf_pkg::REG_PIN_SEL, 8'h00);
    chk_reg("rx count", rdf_pkg::REG_RX_CNT, 8'h00); // empty
    chk_reg("tx count", rdf_pkg::REG_TX_CNT, 8'h00); // empty
    chk_reg("mask", rdf_pkg::REG_INT_MASK, 8'h00);
    wr_reg(4'hc, 8'hff);
    chk_reg("unmapped", 4'hc, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_rx();
    wr_reg(rdf_pkg::REG_PIN_SEL, 8'h00); // receive flag
    for (int s = 0; s < 16; s++) begin
      wr_reg(rdf_pkg::REG_CFG, 8'(s)); // every level
      for (int n = 4 * s; n < 4 * s + 4; n++) begin
        if (n == 4 * s + 3) begin
          settle();
          chk("rx below", 1'b0, general_output_pin);
        end
        push_rx(8'(n * 5 + 1));
      end
      settle();
      chk("rx at level", 1'b1, general_output_pin);
    end
    chk_reg("rx full", rdf_pkg::REG_RX_CNT, 8'h40); // 64 held
    wr_reg(rdf_pkg::REG_PIN_SEL, 8'h01); // unused code drives low
    settle();
    chk("pin other code", 1'b0, general_output_pin);
    wr_reg(rdf_pkg::REG_PIN_SEL, 8'h00);
    push_rx(8'hee);
    chk_reg("rx ovf", rdf_pkg::REG_RX_CNT, 8'hc0); // sticky
    chk_reg("events", rdf_pkg::REG_INT_STAT, 8'h05);
    chk("irq masked", 1'b0, irq);
    wr_reg(rdf_pkg::REG_INT_MASK, 8'h01);
    settle();
    chk("irq on", 1'b1, irq);
    wr_reg(rdf_pkg::REG_INT_STAT, 8'h05);
    settle();
    chk("irq cleared", 1'b0, irq);
    chk_reg("rx poll", rdf_pkg::REG_RX_CNT, 8'hc0); // equal polls
    // whole packet is in before reading
    frame(8'h80, 8'h00, 8'h0f, 8'h01); // saturated nibble
    settle();
    chk("rx drained", 1'b0, general_output_pin); // below level
    chk_reg("rx 63", rdf_pkg::REG_RX_CNT, 8'hbf); // still sticky
    wr_reg(rdf_pkg::REG_CMD, 8'h01);
    chk_reg("rx flushed", rdf_pkg::REG_RX_CNT, 8'h00); // flush
    $display("receive test done");
  endtask

  // refill while the last byte is popped repeats that byte
  task automatic t_clash();
    logic [7:0] s, d;
    push_rx(8'h5a);
    fork
      begin
        host_u.sel();
        host_u.shift(8'h80, s);
        host_u.shift(8'h00, d);
        host_u.desel();
      end
      begin
        // the pop strobe marks the edge the new byte must meet
        @(posedge dut_u.spi_rd_pop);
        rx_byte_valid <= 1'b1;
        rx_byte_data <= 8'ha5;
        @(posedge core_clk);
        rx_byte_valid <= 1'b0;
      end
    join
    chk("clash status", 8'h01, s);
    chk("clash byte", 8'h5a, d);
    chk_reg("clash count", rdf_pkg::REG_RX_CNT, 8'h02);
    frame(8'h80, 8'h00, 8'h02, 8'h5a); // byte read twice
    frame(8'h80, 8'h00, 8'h01, 8'ha5);
    $display("clash test done");
  endtask

  task automatic t_tx();
    wr_reg(rdf_pkg::REG_PIN_SEL, 8'h02); // transmit flag
    // 61 bytes at most, never beyond capacity
    for (int s = 15; s >= 0; s--) begin
      wr_reg(rdf_pkg::REG_CFG, 8'(s)); // every level
      for (int n = (s == 15) ? 0 : 57 - 4 * s; n < 61 - 4 * s; n++) begin
        if (n == 60 - 4 * s) begin
          @(negedge core_clk);
          chk("tx below", 1'b0, general_output_pin);
        end
        frame(8'h00, 8'(n ^ 8'h3c), 8'(n > 15 ? 15 : n), 8'h00);
      end
      settle();
      chk("tx at level", 1'b1, general_output_pin);
    end
    chk_reg("tx count", rdf_pkg::REG_TX_CNT, 8'h3d); // 61 queued
    for (int n = 0; n < 62; n++) begin
      @(posedge core_clk);
      tx_byte_req <= 1'b1;
      @(posedge core_clk);
      tx_byte_req <= 1'b0;
      @(negedge core_clk);
      chk("tx valid", 8'(n < 61), tx_byte_valid); // empty gives none
      if (n < 61) chk("tx data", 8'(n ^ 8'h3c), tx_byte_data);
    end
    chk_reg("tx udf", rdf_pkg::REG_TX_CNT, 8'h80); // sticky
    chk_reg("events", rdf_pkg::REG_INT_STAT, 8'h0a);
    wr_reg(rdf_pkg::REG_INT_MASK, 8'h02);
    settle();
    chk("irq on", 1'b1, irq);
    wr_reg(rdf_pkg::REG_INT_STAT, 8'h0a);
    wr_reg(rdf_pkg::REG_CMD, 8'h02);
    settle();
    chk("irq cleared", 1'b0, irq);
    chk_reg("tx flushed", rdf_pkg::REG_TX_CNT, 8'h00); // flush
    $display("transmit test done");
  endtask

  // ======================================================
  // main sequence
  initial begin
    reset = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte_data = 8'h00;
    tx_byte_req = 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_rx();
    t_clash();
    t_tx();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== include/rdf_pkg.sv ====
// constants and types shared by the radio data buffer pair
`default_nettype none
package rdf_pkg;

  // ==========================================================
  // buffer geometry
  localparam int BUF_DEPTH = 64;
  localparam int DATA_W = 8;
  localparam int PTR_W = 6;
  localparam int CNT_W = 7;
  localparam logic [6:0] CNT_FULL = 7'h40;
  localparam logic [6:0] FILL_SAT = 7'h0f;

  // ==========================================================
  // threshold coding
  localparam logic [6:0] RX_THR_STEP = 7'h04;
  localparam logic [6:0] TX_THR_TOP = 7'h3d;

  // ==========================================================
  // register indexes on the plain register port
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_PIN_SEL = 4'h1;
  localparam logic [3:0] REG_RX_CNT = 4'h2;
  localparam logic [3:0] REG_TX_CNT = 4'h3;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_INT_STAT = 4'h5;
  localparam logic [3:0] REG_INT_MASK = 4'h6;

  // ==========================================================
  // field positions
  localparam int CMD_FLUSH_RX = 0;
  localparam int CMD_FLUSH_TX = 1;
  localparam int INT_RX_OVF = 0;
  localparam int INT_TX_UDF = 1;
  localparam int INT_RX_THR = 2;
  localparam int INT_TX_THR = 3;
  localparam int HDR_RW_BIT = 7;

  // ==========================================================
  // reset values and selector codes
  localparam logic [3:0] THR_RESET = 4'h7;
  localparam logic [5:0] PIN_SEL_RESET = 6'h00;
  localparam logic [3:0] INT_MASK_RESET = 4'h0;
  localparam logic [5:0] PIN_SEL_RX_THR = 6'h00;
  localparam logic [5:0] PIN_SEL_TX_THR = 6'h02;
  localparam logic STATUS_RDY_N = 1'b0;
  localparam logic [2:0] STATUS_STATE = 3'h0;

  // ==========================================================
  // serial transfer phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_HDR = 2'b01,
    PH_DATA = 2'b10
  } rdf_phase_t;

endpackage
`default_nettype wire

// ==== rtl/rdf_byte_buf.sv ====
// one 64-entry byte buffer with fill count
`timescale 1ns/1ns
`default_nettype none
module rdf_byte_buf #(
  parameter bit DUP_ON_CLASH = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // fill side
  input wire logic flush,
  input wire logic push,
  input wire logic [7:0] push_data,
  // drain side
  input wire logic pop,
  output logic [7:0] head_data,
  // level
  output logic [6:0] count,
  output logic full,
  output logic empty
);

  // ==========================================================
  // storage and pointers
  logic [7:0] mem [0:rdf_pkg::BUF_DEPTH-1];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic do_push;
  logic do_pop;
  logic clash;
  logic adv_pop;
  logic [6:0] next_count;

  // a push into a full buffer is dropped, so excess bytes are lost
  assign full = (count == rdf_pkg::CNT_FULL);
  assign empty = (count == 7'h00);
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  // refill on the last byte keeps the read pointer: byte repeats
  assign clash = DUP_ON_CLASH & do_push & do_pop & (count == 7'h01);
  assign adv_pop = do_pop & ~clash;
  assign next_count = count + {6'h00, do_push} - {6'h00, adv_pop};
  // past empty the head shows a stale entry
  assign head_data = mem[rd_ptr];

  // pointer and count update, flush empties the buffer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      count <= 7'h00;
    end else if (flush) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      count <= 7'h00;
    end else begin
      wr_ptr <= wr_ptr + {5'h00, do_push};
      rd_ptr <= rd_ptr + {5'h00, adv_pop};
      count <= next_count;
    end
  end

  // storage carries no reset to keep it plain flip-flops
  always_ff @(posedge core_clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr] <= push_data;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/rdf_radio_fifo.sv ====
// top of the radio data buffer pair: buffers, serial access, registers
//
// Overview of operation
// - two independent 64-byte buffers, receive and transmit
// - host reads receive, writes transmit, serially only
// - detect receive overflow and transmit underflow
// - header status byte carries direction's fill level
// - both byte counts readable as status fields
// - receive refill while reading last byte repeats it
// - four-bit field picks one of sixteen levels
// - receive 4*(s+1), transmit 61-4*s bytes
// - threshold flag when count reaches level
// - pin code 0 receive, code 2 transmit
// - receive flag drops below same threshold
`timescale 1ns/1ns
`default_nettype none
module rdf_radio_fifo (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe_n,
  // demodulator side
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  // modulator side
  input wire logic tx_byte_req,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte_data,
  // pin and interrupt
  output logic general_output_pin,
  output logic irq
);

  // ==========================================================
  // helpers

  // status nibble saturates since it has only four bits
  function automatic logic [3:0] fill_nibble(input logic [6:0] cnt);
    fill_nibble = (cnt > rdf_pkg::FILL_SAT) ? 4'hf : cnt[3:0];
  endfunction

  // ==========================================================
  // declarations
  logic [3:0] threshold_level_select;
  logic [5:0] output_pin_signal_select;
  logic [3:0] int_status;
  logic [3:0] int_mask;
  logic rx_err;
  logic tx_err;
  logic rx_above_q;
  logic tx_above_q;
  logic [6:0] rx_count;
  logic [6:0] tx_count;
  logic rx_full, rx_empty;
  logic tx_full, tx_empty;
  logic [7:0] rx_head;
  logic [7:0] tx_head;
  logic spi_rd_pop;
  logic spi_wr_push;
  logic [7:0] spi_wr_data;
  logic wr_cfg, wr_pin, wr_cmd, wr_int, wr_mask;
  logic flush_rx, flush_tx;
  logic [6:0] rx_thr;
  logic [6:0] tx_thr;
  logic rx_above, tx_above;
  logic rx_ovf_ev, tx_udf_ev;
  logic rx_thr_ev, tx_thr_ev;
  logic [3:0] int_events;
  logic [3:0] int_clear;
  logic [3:0] next_int_status;
  logic next_rx_err, next_tx_err;
  logic next_pin;
  logic [7:0] receive_count_status;
  logic [7:0] transmit_count_status;
  logic [7:0] read_value;

  // ==========================================================
  // buffers

  // receive side carries the last-byte clash behaviour
  rdf_byte_buf #(
    .DUP_ON_CLASH(1'b1)
  ) u_rx_buf (
    .core_clk(core_clk),
    .reset(reset),
    .flush(flush_rx),
    .push(rx_byte_valid),
    .push_data(rx_byte_data),
    .pop(spi_rd_pop),
    .head_data(rx_head),
    .count(rx_count),
    .full(rx_full),
    .empty(rx_empty)
  );

  rdf_byte_buf #(
    .DUP_ON_CLASH(1'b0)
  ) u_tx_buf (
    .core_clk(core_clk),
    .reset(reset),
    .flush(flush_tx),
    .push(spi_wr_push),
    .push_data(spi_wr_data),
    .pop(tx_byte_req),
    .head_data(tx_head),
    .count(tx_count),
    .full(tx_full),
    .empty(tx_empty)
  );

  // ==========================================================
  // serial access

  rdf_spi_slave u_spi (
    .core_clk(core_clk),
    .reset(reset),
    .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin),
    .si_pin(si_pin),
    .so_out(so_out),
    .so_oe_n(so_oe_n),
    .rx_fill(fill_nibble(rx_count)),
    .tx_fill(fill_nibble(tx_count)),
    .rd_head(rx_head),
    .rd_pop(spi_rd_pop),
    .wr_push(spi_wr_push),
    .wr_data(spi_wr_data)
  );

  // modulator gets the head byte one cycle after its request
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_byte_valid <= 1'b0;
      tx_byte_data <= 8'h00;
    end else begin
      tx_byte_valid <= tx_byte_req & ~tx_empty;
      if (tx_byte_req && !tx_empty) tx_byte_data <= tx_head;
    end
  end

  // ==========================================================
  // thresholds

  // opposite coding gives equal margin to overflow and underflow
  assign rx_thr = {1'b0, threshold_level_select, 2'b00}
                + rdf_pkg::RX_THR_STEP;
  assign tx_thr = rdf_pkg::TX_THR_TOP
                - {1'b0, threshold_level_select, 2'b00};
  // compare is level based, so it falls as soon as the count drops
  assign rx_above = (rx_count >= rx_thr);
  assign tx_above = (tx_count >= tx_thr);
  assign next_pin =
    (output_pin_signal_select == rdf_pkg::PIN_SEL_RX_THR) ? rx_above :
    (output_pin_signal_select == rdf_pkg::PIN_SEL_TX_THR) ? tx_above :
    1'b0;

  // ==========================================================
  // events and sticky flags
  assign rx_ovf_ev = rx_byte_valid & rx_full;
  assign tx_udf_ev = tx_byte_req & tx_empty;
  assign rx_thr_ev = rx_above & ~rx_above_q;
  assign tx_thr_ev = tx_above & ~tx_above_q;
  assign int_events = {tx_thr_ev, rx_thr_ev, tx_udf_ev, rx_ovf_ev};
  assign int_clear = wr_int ? reg_wdata[3:0] : 4'h0;
  // a new event beats a clear in the same cycle
  assign next_int_status = (int_status & ~int_clear) | int_events;
  assign next_rx_err = (rx_err & ~flush_rx) | rx_ovf_ev;
  assign next_tx_err = (tx_err & ~flush_tx) | tx_udf_ev;
  assign irq = |(int_status & int_mask);

  // ==========================================================
  // register decode
  assign wr_cfg = reg_wr & (reg_addr == rdf_pkg::REG_CFG);
  assign wr_pin = reg_wr & (reg_addr == rdf_pkg::REG_PIN_SEL);
  assign wr_cmd = reg_wr & (reg_addr == rdf_pkg::REG_CMD);
  assign wr_int = reg_wr & (reg_addr == rdf_pkg::REG_INT_STAT);
  assign wr_mask = reg_wr & (reg_addr == rdf_pkg::REG_INT_MASK);
  assign flush_rx = wr_cmd & reg_wdata[rdf_pkg::CMD_FLUSH_RX];
  assign flush_tx = wr_cmd & reg_wdata[rdf_pkg::CMD_FLUSH_TX];
  assign receive_count_status = {rx_err, rx_count};
  assign transmit_count_status = {tx_err, tx_count};
  // unmapped indexes and the command register read as zero
  assign read_value =
    (reg_addr == rdf_pkg::REG_CFG) ? {4'h0, threshold_level_select} :
    (reg_addr == rdf_pkg::REG_PIN_SEL) ?
      {2'h0, output_pin_signal_select} :
    (reg_addr == rdf_pkg::REG_RX_CNT) ? receive_count_status :
    (reg_addr == rdf_pkg::REG_TX_CNT) ? transmit_count_status :
    (reg_addr == rdf_pkg::REG_INT_STAT) ? {4'h0, int_status} :
    (reg_addr == rdf_pkg::REG_INT_MASK) ? {4'h0, int_mask} :
    8'h00;

  // software-written configuration
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      threshold_level_select <= rdf_pkg::THR_RESET;
      output_pin_signal_select <= rdf_pkg::PIN_SEL_RESET;
      int_mask <= rdf_pkg::INT_MASK_RESET;
    end else begin
      if (wr_cfg) threshold_level_select <= reg_wdata[3:0];
      if (wr_pin) output_pin_signal_select <= reg_wdata[5:0];
      if (wr_mask) int_mask <= reg_wdata[3:0];
    end
  end

  // hardware-written state and read data
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_status <= 4'h0;
      rx_err <= 1'b0;
      tx_err <= 1'b0;
      rx_above_q <= 1'b0;
      tx_above_q <= 1'b0;
      general_output_pin <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      int_status <= next_int_status;
      rx_err <= next_rx_err;
      tx_err <= next_tx_err;
      rx_above_q <= rx_above;
      tx_above_q <= tx_above;
      general_output_pin <= next_pin;
      reg_rdata <= reg_rd ? read_value : 8'h00;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_last_clash;
    rx_byte_valid && spi_rd_pop && (rx_count == 7'h01) && !flush_rx;
  endsequence

  sequence s_rx_below;
    (output_pin_signal_select == 6'h00) && (rx_count < rx_thr);
  endsequence

  sequence s_count_read;
    reg_rd && (reg_addr == rdf_pkg::REG_RX_CNT);
  endsequence

  buf_cap_a: assert property (
    (rx_count <= 7'h40) && (tx_count <= 7'h40))
    else $error("buffer count above 64");

  rx_ovf_a: assert property (
    (rx_byte_valid && rx_full && !spi_rd_pop && !flush_rx) |=>
      rx_err && int_status[rdf_pkg::INT_RX_OVF] && rx_count == 7'h40)
    else $error("receive overflow not flagged");

  tx_udf_a: assert property (
    (tx_byte_req && tx_empty) |=> tx_err && !tx_byte_valid)
    else $error("transmit underflow not flagged");

  last_dup_a: assert property (
    s_last_clash |=> (rx_count == 7'h02) && (rx_head == $past(rx_head)))
    else $error("clash did not repeat the last byte");

  rx_thr_calc_a: assert property (
    rx_above == ({1'b0, rx_count} >=
      ({4'h0, threshold_level_select} + 8'h01) * 8'h04))
    else $error("receive threshold level wrong");

  tx_thr_calc_a: assert property (
    tx_above == ({1'b0, tx_count}
      + {2'h0, threshold_level_select, 2'b00} >= 8'h3d))
    else $error("transmit threshold level wrong");

  rx_pin_a: assert property (
    (output_pin_signal_select == 6'h00) ##1
      (output_pin_signal_select == 6'h00) |->
      general_output_pin == $past(rx_above))
    else $error("pin does not follow receive threshold");

  tx_pin_a: assert property (
    (output_pin_signal_select == 6'h02) |=>
      general_output_pin == $past(tx_above))
    else $error("pin does not follow transmit threshold");

  rx_drop_a: assert property (
    s_rx_below |=> !general_output_pin)
    else $error("receive threshold pin stuck high");

  count_read_a: assert property (
    s_count_read |=> (reg_rdata[6:0] == $past(rx_count))
      ##1 (reg_rdata == 8'h00 || $past(reg_rd)))
    else $error("receive count read back wrong");

  cfg_write_a: assert property (
    (reg_wr && reg_addr == rdf_pkg::REG_CFG) |=>
      {4'h0, threshold_level_select} == ($past(reg_wdata) & 8'h0f))
    else $error("threshold select not stored");

  err_hold_a: assert property (
    (rx_err && !flush_rx) |=> rx_err [*2] or
      (rx_err ##1 $past(flush_rx)))
    else $error("overflow flag lost without flush");

  err_clear_a: assert property (
    (flush_tx && !tx_byte_req) |=> !tx_err && tx_count == 7'h00)
    else $error("flush did not clear transmit error");

endmodule
`default_nettype wire

// ==== rtl/rdf_spi_slave.sv ====
// serial peripheral slave that moves bytes into and out of the buffers
`timescale 1ns/1ns
`default_nettype none
module rdf_spi_slave (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // serial pins
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic si_pin,
  output logic so_out,
  output logic so_oe_n,
  // buffer side
  input wire logic [3:0] rx_fill,
  input wire logic [3:0] tx_fill,
  input wire logic [7:0] rd_head,
  output logic rd_pop,
  output logic wr_push,
  output logic [7:0] wr_data
);

  // ==========================================================
  // pin synchronisers and edge finding
  logic cs_s1, cs_s2, cs_q;
  logic sclk_s1, sclk_s2, sclk_q;
  logic si_s1, si_s2;
  logic selected, sclk_rise, sclk_fall, cs_start, byte_done;
  logic rw;
  logic [2:0] bit_cnt;
  logic [2:0] bit_idx;
  logic [6:0] shift_in;
  logic [7:0] out_byte;
  logic [7:0] status;
  rdf_pkg::rdf_phase_t phase, next_phase;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      {cs_s1, cs_s2, cs_q} <= 3'h7;
      {sclk_s1, sclk_s2, sclk_q} <= 3'h0;
      {si_s1, si_s2} <= 2'h0;
    end else begin
      {cs_s1, cs_s2, cs_q} <= {cs_n_pin, cs_s1, cs_s2};
      {sclk_s1, sclk_s2, sclk_q} <= {sclk_pin, sclk_s1, sclk_s2};
      {si_s1, si_s2} <= {si_pin, si_s1};
    end
  end

  assign selected = ~cs_s2;
  assign so_oe_n = cs_s2;
  assign sclk_rise = selected & sclk_s2 & ~sclk_q;
  assign sclk_fall = selected & ~sclk_s2 & sclk_q;
  assign cs_start = cs_q & ~cs_s2;
  assign byte_done = sclk_rise & (bit_cnt == 3'h7);
  assign bit_idx = 3'h7 - bit_cnt;
  // status shows receive fill on reads, transmit fill on writes
  assign status = {rdf_pkg::STATUS_RDY_N, rdf_pkg::STATUS_STATE,
                   rw ? rx_fill : tx_fill};

  // ==========================================================
  // transfer phase
  always_comb begin
    next_phase = phase;
    case (phase)
      rdf_pkg::PH_IDLE: begin
        if (cs_start) next_phase = rdf_pkg::PH_HDR;
      end
      rdf_pkg::PH_HDR: begin
        if (!selected) next_phase = rdf_pkg::PH_IDLE;
        else if (byte_done) next_phase = rdf_pkg::PH_DATA;
      end
      rdf_pkg::PH_DATA: begin
        if (!selected) next_phase = rdf_pkg::PH_IDLE;
      end
      default: next_phase = rdf_pkg::PH_IDLE;
    endcase
  end

  // inbound bits on rising sclk, one pop or push per data byte
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase <= rdf_pkg::PH_IDLE;
      bit_cnt <= 3'h0;
      rw <= 1'b0;
      shift_in <= 7'h00;
      rd_pop <= 1'b0;
      wr_push <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      phase <= next_phase;
      rd_pop <= byte_done & (phase == rdf_pkg::PH_DATA) & rw;
      wr_push <= byte_done & (phase == rdf_pkg::PH_DATA) & ~rw;
      if (cs_start) begin
        bit_cnt <= 3'h0;
        rw <= 1'b0;
      end else if (sclk_rise) begin
        bit_cnt <= bit_cnt + 3'h1;
        shift_in <= {shift_in[5:0], si_s2};
        if (phase == rdf_pkg::PH_HDR && bit_cnt == 3'h0) rw <= si_s2;
        if (byte_done) wr_data <= {shift_in, si_s2};
      end
    end
  end

  // outbound bits change on falling sclk, msb first
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      so_out <= 1'b0;
      out_byte <= 8'h00;
    end else if (cs_start) begin
      so_out <= rdf_pkg::STATUS_RDY_N;
    end else if (sclk_fall) begin
      if (phase == rdf_pkg::PH_HDR) begin
        so_out <= status[bit_idx];
      end else if (rw && bit_cnt == 3'h0) begin
        out_byte <= rd_head;
        so_out <= rd_head[7];
      end else begin
        so_out <= rw & out_byte[bit_idx];
      end
    end
  end

endmodule
`default_nettype wire
